/* File: verilog/ocs_map.vh */
/*
 * Constants of the phase overcurrent stage: settings, scales, codes.
 * Assumes magnitudes and thresholds in hundredths of nominal current.
 */
`ifndef OCS_MAP_VH
`define OCS_MAP_VH

// Clock rate and program cycle
`define OCS_CLK_MHZ 250
`define OCS_CYCLE_TIME_US 5000
`define OCS_CYCLE_CLKS (`OCS_CLK_MHZ * `OCS_CYCLE_TIME_US)

// Threshold default, 1.20 x In in 0.01 steps
`define OCS_THR_RST 16'h0078
// Reset fraction and its percent base
`define OCS_RESET_PCT 8'h61
`define OCS_PCT_FULL 8'h64
// Harmonic limit in 0.01 % steps, full scale 100.00 %
`define OCS_HARM_FULL 16'h2710
`define OCS_HARM_LIM_RST 16'h0001

// Measured magnitude selection
`define OCS_MAG_FUND 2'h0
`define OCS_MAG_TRMS 2'h1
`define OCS_MAG_PP 2'h2

// Overall stage condition codes
`define OCS_COND_NORMAL 2'h0
`define OCS_COND_START 2'h1
`define OCS_COND_TRIP 2'h2
`define OCS_COND_BLOCKED 2'h3

// Forced status: 0 keeps natural, 1..3 as condition, 8+mask start, 16+mask trip
`define OCS_FORCE_NORMAL 5'h00
`define OCS_FORCE_START 5'h01
`define OCS_FORCE_TRIP 5'h02
`define OCS_FORCE_BLOCKED 5'h03
`define OCS_FORCE_PH_START 2'h1
`define OCS_FORCE_PH_TRIP 2'h2

`endif

/* File: verilog/ocs_cycle_tick.v */
/*
 * Program cycle divider: one-cycle tick every CYCLE_CLKS clocks.
 * Assumes a synchronised active-low reset from the stage top.
 */
module ocs_cycle_tick #(
  parameter CYCLE_CLKS = 1250000
) (
  input wire clock,
  input wire rst_n,
  output reg tick
);
  reg [31:0] count_reg;

  // Free-running divider; tick marks the start of each cycle
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 32'h00000000;
      tick <= 1'b0;
    end else if (count_reg >= CYCLE_CLKS - 1) begin
      count_reg <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule

/* File: verilog/ocs_phase_cmp.v */
/*
 * One phase pick-up comparator with fixed reset ratio.
 * Assumes magnitude and threshold in the same 0.01 x In unit.
 */
`include "ocs_map.vh"
module ocs_phase_cmp #(
  parameter W = 16
) (
  input wire clock,
  input wire rst_n,
  input wire tick,
  input wire [W-1:0] mag,
  input wire [W-1:0] thr,
  output reg pickup
);
  wire [W+7:0] mag_pct;
  wire [W+7:0] thr_pct;
  wire [W+7:0] rel_pct;

  // Scaled so 97 % compares without a divider
  assign mag_pct = {8'h00, mag} * {{W{1'b0}}, `OCS_PCT_FULL};
  assign thr_pct = {8'h00, thr} * {{W{1'b0}}, `OCS_PCT_FULL};
  assign rel_pct = {8'h00, thr} * {{W{1'b0}}, `OCS_RESET_PCT};

  // Set above threshold, clear only below 97 % of it
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pickup <= 1'b0;
    end else if (tick) begin
      if (mag_pct > thr_pct) begin
        pickup <= 1'b1;
      end else if (mag_pct < rel_pct) begin
        pickup <= 1'b0;
      end
    end
  end
endmodule

/* File: verilog/ocs_stage.v */
/*
 * Non-directional phase overcurrent stage: pick-up, blocking, timer,
 * forcing, operating-time reports and current ratio.
 * Assumes magnitudes arrive every program cycle, and the operating
 * delay comes from an outside time characteristic in cycle units.
 */
`include "ocs_map.vh"
// Operation
// - General configuration static, ignores group switching.
// - Remote threshold write only when permitted.
// - Forcing overrides status; default normal.
// - Select fundamental, true RMS or peak-to-peak.
// - Pick-up when any phase exceeds threshold.
// - Release only below 97 % of threshold.
// - One threshold, 0.01 steps, default 1.20.
// - Setting groups change parameters while running.
// - Overall condition: normal, start, trip, blocked.
// - Per-phase start and trip condition.
// - Expected operating time in 5 ms steps.
// - Remaining time to trip in 5 ms steps.
// - Ratio of highest current to threshold.
// - Sample external block once per cycle.
// - Unblocked pick-up raises start, starts timer.
// - Blocked pick-up raises blocked, nothing more.
// - Late block runs release, then clears start.
// - Optional inrush block inhibits trip only.
// - Inrush when harmonic ratio reaches limit.
module ocs_stage #(
  parameter W = 16,
  parameter TW = 19,
  parameter CYCLE_CLKS = `OCS_CYCLE_CLKS
) (
  input wire clock,
  input wire rst_n,
  input wire [3*W-1:0] fund_mag,
  input wire [3*W-1:0] trms_mag,
  input wire [3*W-1:0] pp_mag,
  input wire [3*W-1:0] harm2_mag,
  input wire block_in,
  input wire cfg_write,
  input wire cfg_remote_allow,
  input wire cfg_force_enable,
  input wire [4:0] cfg_forced_status_select,
  input wire [1:0] cfg_mag_select,
  input wire cfg_inrush_enable,
  input wire [W-1:0] cfg_inrush_limit,
  input wire grp_load,
  input wire [W-1:0] grp_threshold,
  input wire [TW-1:0] op_delay,
  input wire [TW-1:0] release_delay,
  input wire remote_write,
  input wire [W-1:0] remote_threshold,
  output reg [1:0] stage_condition,
  output reg [2:0] phase_start,
  output reg [2:0] phase_trip,
  output reg [W-1:0] threshold,
  output reg [W-1:0] max_mag,
  output reg [TW-1:0] expected_time,
  output reg [TW+1:0] remaining_time,
  output reg [19:0] current_ratio,
  output reg inrush_active
);
  // One-hot stage states
  localparam [4:0] ST_NORMAL = 5'h01;
  localparam [4:0] ST_START = 5'h02;
  localparam [4:0] ST_TRIP = 5'h04;
  localparam [4:0] ST_BLOCKED = 5'h08;
  localparam [4:0] ST_RELEASE = 5'h10;
  localparam [TW-1:0] CNT_ONE = 1;

  reg rst_meta_reg;
  reg rst_sync_reg;
  reg remote_allow_reg;
  reg force_enable_reg;
  reg [4:0] force_sel_reg;
  reg [1:0] mag_sel_reg;
  reg inrush_enable_reg;
  reg [W-1:0] inrush_limit_reg;
  reg block_reg;
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [TW-1:0] op_count_reg;
  reg [TW-1:0] op_count_next;
  reg [TW-1:0] rel_count_reg;
  reg [TW-1:0] rel_count_next;
  reg [2:0] start_ph_reg;
  reg [2:0] start_ph_next;
  reg tick_d_reg;
  reg [23:0] dvd_reg;
  reg [W:0] rem_reg;
  reg [19:0] quo_reg;
  reg [4:0] div_step_reg;
  reg div_busy_reg;
  reg [1:0] cond_raw;
  reg [2:0] ph_start_raw;
  reg [2:0] ph_trip_raw;
  reg [W-1:0] max_now;
  reg inrush_now;
  wire tick;
  wire [2:0] pickup;
  wire [3*W-1:0] sel_mag;
  wire any_pickup;
  wire timer_done;
  wire release_done;
  wire [W+1:0] rem_shift;
  wire [W+1:0] thr_ext;
  integer i;

  // Pick one phase magnitude from the selected source
  function [W-1:0] mag_pick;
    input [1:0] sel;
    input [W-1:0] f;
    input [W-1:0] t;
    input [W-1:0] p;
    begin
      case (sel)
        `OCS_MAG_TRMS: mag_pick = t;
        `OCS_MAG_PP: mag_pick = p;
        default: mag_pick = f;
      endcase
    end
  endfunction

  // Asynchronous assert, two-flop release of reset
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  ocs_cycle_tick #(
    .CYCLE_CLKS(CYCLE_CLKS)
  ) u_tick (
    .clock(clock),
    .rst_n(rst_sync_reg),
    .tick(tick)
  );

  // Per-phase magnitude selection and hysteresis comparator
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_phase
      assign sel_mag[g*W +: W] = mag_pick(mag_sel_reg,
        fund_mag[g*W +: W], trms_mag[g*W +: W],
        pp_mag[g*W +: W]);
      ocs_phase_cmp #(
        .W(W)
      ) u_cmp (
        .clock(clock),
        .rst_n(rst_sync_reg),
        .tick(tick),
        .mag(sel_mag[g*W +: W]),
        .thr(threshold),
        .pickup(pickup[g])
      );
    end
  endgenerate

  assign any_pickup = |pickup;

  // Static settings only move on an explicit configuration write
  always @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      remote_allow_reg <= 1'b0;
      force_enable_reg <= 1'b0;
      force_sel_reg <= `OCS_FORCE_NORMAL;
      mag_sel_reg <= `OCS_MAG_FUND;
      inrush_enable_reg <= 1'b0;
      inrush_limit_reg <= `OCS_HARM_LIM_RST;
    end else if (cfg_write) begin
      remote_allow_reg <= cfg_remote_allow;
      force_enable_reg <= cfg_force_enable;
      force_sel_reg <= cfg_forced_status_select;
      mag_sel_reg <= cfg_mag_select;
      inrush_enable_reg <= cfg_inrush_enable;
      inrush_limit_reg <= cfg_inrush_limit;
    end
  end

  // Threshold: group load or permitted remote write, no restart
  always @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      threshold <= `OCS_THR_RST;
    end else if (remote_write && remote_allow_reg) begin
      threshold <= remote_threshold;
    end else if (grp_load) begin
      threshold <= grp_threshold;
    end
  end

  // Highest phase current and second-harmonic test on all phases
  always @* begin
    max_now = sel_mag[W-1:0];
    inrush_now = 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      if (sel_mag[i*W +: W] > max_now) begin
        max_now = sel_mag[i*W +: W];
      end
      // Full-width products; an idle phase with no current is no inrush
      if (fund_mag[i*W +: W] != {W{1'b0}} &&
        {{W{1'b0}}, harm2_mag[i*W +: W]} * {{W{1'b0}}, `OCS_HARM_FULL} >=
        {{W{1'b0}}, inrush_limit_reg} * {{W{1'b0}}, fund_mag[i*W +: W]}) begin
        inrush_now = 1'b1;
      end
    end
  end

  // Sample block, inrush and peak current at each cycle start
  always @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      block_reg <= 1'b0;
      inrush_active <= 1'b0;
      max_mag <= {W{1'b0}};
      tick_d_reg <= 1'b0;
    end else begin
      tick_d_reg <= tick;
      if (tick) begin
        block_reg <= block_in;
        inrush_active <= inrush_enable_reg & inrush_now;
        max_mag <= max_now;
      end
    end
  end

  // Timer expiry; inrush holds the stage in start, never trips
  assign timer_done = (op_count_reg + CNT_ONE >= op_delay);
  assign release_done = (rel_count_reg + CNT_ONE >= release_delay);

  // Stage sequence, evaluated one clock after each cycle tick
  always @* begin
    state_next = state_reg;
    op_count_next = op_count_reg;
    rel_count_next = rel_count_reg;
    start_ph_next = start_ph_reg;
    case (state_reg)
      ST_NORMAL: begin
        op_count_next = {TW{1'b0}};
        rel_count_next = {TW{1'b0}};
        start_ph_next = 3'h0;
        if (any_pickup && block_reg) begin
          state_next = ST_BLOCKED;
        end else if (any_pickup) begin
          state_next = ST_START;
          start_ph_next = pickup;
        end
      end
      ST_BLOCKED: begin
        if (!any_pickup) begin
          state_next = ST_NORMAL;
        end else if (!block_reg) begin
          state_next = ST_START;
          start_ph_next = pickup;
        end
      end
      ST_START: begin
        rel_count_next = {TW{1'b0}};
        if (block_reg || !any_pickup) begin
          state_next = ST_RELEASE;
        end else begin
          start_ph_next = pickup;
          if (timer_done && !inrush_active) begin
            state_next = ST_TRIP;
          end else if (!timer_done) begin
            op_count_next = op_count_reg + CNT_ONE;
          end
        end
      end
      ST_TRIP: begin
        start_ph_next = pickup;
        if (block_reg || !any_pickup) begin
          state_next = ST_NORMAL;
        end
      end
      ST_RELEASE: begin
        if (any_pickup && !block_reg) begin
          state_next = ST_START;
          start_ph_next = pickup;
        end else if (release_done) begin
          state_next = ST_NORMAL;
        end else begin
          rel_count_next = rel_count_reg + CNT_ONE;
        end
      end
      default: begin
        state_next = ST_NORMAL;
      end
    endcase
  end

  // Stage state; the timer is held while start is released
  always @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= ST_NORMAL;
      op_count_reg <= {TW{1'b0}};
      rel_count_reg <= {TW{1'b0}};
      start_ph_reg <= 3'h0;
    end else if (tick_d_reg) begin
      state_reg <= state_next;
      op_count_reg <= op_count_next;
      rel_count_reg <= rel_count_next;
      start_ph_reg <= start_ph_next;
    end
  end

  // Natural condition, then forcing on top of it
  always @* begin
    cond_raw = `OCS_COND_NORMAL;
    ph_start_raw = 3'h0;
    ph_trip_raw = 3'h0;
    case (state_reg)
      ST_START, ST_RELEASE: begin
        cond_raw = `OCS_COND_START;
        ph_start_raw = start_ph_reg;
      end
      ST_TRIP: begin
        cond_raw = `OCS_COND_TRIP;
        ph_trip_raw = start_ph_reg;
      end
      ST_BLOCKED: begin
        cond_raw = `OCS_COND_BLOCKED;
      end
      default: begin
        cond_raw = `OCS_COND_NORMAL;
      end
    endcase
    if (force_enable_reg && force_sel_reg != `OCS_FORCE_NORMAL) begin
      ph_start_raw = 3'h0;
      ph_trip_raw = 3'h0;
      if (force_sel_reg[4:3] == `OCS_FORCE_PH_START) begin
        cond_raw = `OCS_COND_START;
        ph_start_raw = force_sel_reg[2:0];
      end else if (force_sel_reg[4:3] == `OCS_FORCE_PH_TRIP) begin
        cond_raw = `OCS_COND_TRIP;
        ph_trip_raw = force_sel_reg[2:0];
      end else if (force_sel_reg == `OCS_FORCE_START) begin
        cond_raw = `OCS_COND_START;
        ph_start_raw = 3'h7;
      end else if (force_sel_reg == `OCS_FORCE_TRIP) begin
        cond_raw = `OCS_COND_TRIP;
        ph_trip_raw = 3'h7;
      end else begin
        cond_raw = `OCS_COND_BLOCKED;
      end
    end
  end

  // Registered condition and time reports
  always @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      stage_condition <= `OCS_COND_NORMAL;
      phase_start <= 3'h0;
      phase_trip <= 3'h0;
      expected_time <= {TW{1'b0}};
      remaining_time <= {(TW+2){1'b0}};
    end else begin
      stage_condition <= cond_raw;
      phase_start <= ph_start_raw;
      phase_trip <= ph_trip_raw;
      expected_time <= op_delay;
      // Signed, so a delay shortened mid-fault shows as negative
      if (state_reg == ST_START || state_reg == ST_RELEASE) begin
        remaining_time <= {2'b00, op_delay} -
          {2'b00, op_count_reg};
      end else begin
        remaining_time <= {(TW+2){1'b0}};
      end
    end
  end

  // Ratio by restoring division, 24 steps per cycle; slow but small
  assign rem_shift = {rem_reg, dvd_reg[23]};
  assign thr_ext = {2'b00, threshold};

  always @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      dvd_reg <= 24'h000000;
      rem_reg <= {(W+1){1'b0}};
      quo_reg <= 20'h00000;
      div_step_reg <= 5'h00;
      div_busy_reg <= 1'b0;
      current_ratio <= 20'h00000;
    end else if (tick_d_reg) begin
      dvd_reg <= {8'h00, max_mag} * {{W{1'b0}}, `OCS_PCT_FULL};
      rem_reg <= {(W+1){1'b0}};
      quo_reg <= 20'h00000;
      div_step_reg <= 5'h00;
      div_busy_reg <= (threshold != {W{1'b0}});
    end else if (div_busy_reg) begin
      dvd_reg <= {dvd_reg[22:0], 1'b0};
      if (rem_shift >= thr_ext) begin
        rem_reg <= rem_shift[W:0] - {1'b0, threshold};
        quo_reg <= {quo_reg[18:0], 1'b1};
      end else begin
        rem_reg <= rem_shift[W:0];
        quo_reg <= {quo_reg[18:0], 1'b0};
      end
      div_step_reg <= div_step_reg + 5'h01;
      if (div_step_reg == 5'h17) begin
        div_busy_reg <= 1'b0;
        current_ratio <= (rem_shift >= thr_ext) ?
          {quo_reg[18:0], 1'b1} : {quo_reg[18:0], 1'b0};
      end
    end
  end
endmodule

/* File: bench/ocs_stage_asserts.sv */
/* Port checker of the overcurrent stage, bound to its top.
   Assumes the stage leaves reset two edges after rst_n rises. */
`include "ocs_map.vh"
module ocs_stage_asserts #(
  parameter W = 16,
  parameter TW = 19
) (
  input wire clock,
  input wire rst_n,
  input wire block_in,
  input wire cfg_write,
  input wire cfg_force_enable,
  input wire [4:0] cfg_forced_status_select,
  input wire grp_load,
  input wire [W-1:0] grp_threshold,
  input wire remote_write,
  input wire [TW-1:0] op_delay,
  input wire [1:0] stage_condition,
  input wire [2:0] phase_trip,
  input wire [W-1:0] threshold,
  input wire [TW-1:0] expected_time,
  input wire [TW+1:0] remaining_time,
  input wire inrush_active
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [1:0] up_reg;
  reg frc_reg;
  reg [2:0] fh_reg;
  reg [6:0] bcnt_reg;
  wire quiet;
  // Forcing history stretched, outputs lag the config by two clocks
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      up_reg <= 2'h0;
      frc_reg <= 1'b0;
      fh_reg <= 3'h0;
      bcnt_reg <= 7'h00;
    end else begin
      if (up_reg != 2'h3)
        up_reg <= up_reg + 2'h1;
      if (cfg_write)
        frc_reg <= cfg_force_enable;
      fh_reg <= {fh_reg[1:0], frc_reg};
      if (!block_in)
        bcnt_reg <= 7'h00;
      else if (bcnt_reg != 7'h7F)
        bcnt_reg <= bcnt_reg + 7'h01;
    end
  end
  assign quiet = !frc_reg && fh_reg == 3'h0 && up_reg == 2'h3;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_thr_group_load: assert property (
    up_reg == 2'h3 && grp_load && !remote_write
    |=> threshold == $past(grp_threshold)) else $error("group load lost");
  a_thr_hold: assert property (
    up_reg == 2'h3 && !grp_load && !remote_write |=> $stable(threshold))
    else $error("threshold moved unasked");
  a_exp_time_follow: assert property (
    up_reg == 2'h3 |=> expected_time == $past(op_delay))
    else $error("expected time stale");
  a_trip_from_start: assert property (
    quiet && stage_condition == `OCS_COND_TRIP
    && $past(stage_condition) != `OCS_COND_TRIP
    |-> $past(stage_condition) == `OCS_COND_START)
    else $error("trip without start");
  a_block_no_trip: assert property (
    quiet && bcnt_reg > 7'h38 |-> stage_condition != `OCS_COND_TRIP)
    else $error("trip while blocked");
  a_phase_trip_cond: assert property (
    quiet && phase_trip != 3'h0 |-> stage_condition == `OCS_COND_TRIP)
    else $error("phase trip without trip");
  a_remain_idle: assert property (
    (quiet && stage_condition == `OCS_COND_NORMAL) [*3]
    |-> $past(remaining_time) == 0) else $error("remaining time idle");
  a_force_trip: assert property (
    up_reg == 2'h3 && cfg_write && cfg_force_enable
    && cfg_forced_status_select == `OCS_FORCE_TRIP
    |-> ##[1:3] stage_condition == `OCS_COND_TRIP) else $error("no force");
  a_inrush_no_trip: assert property (
    quiet && inrush_active |=> !(stage_condition == `OCS_COND_TRIP
    && $past(stage_condition) != `OCS_COND_TRIP)) else $error("inrush trip");
  c_start: cover property (stage_condition == `OCS_COND_START);
  c_trip: cover property (quiet && stage_condition == `OCS_COND_TRIP);
  c_blocked: cover property (stage_condition == `OCS_COND_BLOCKED);
  c_inrush: cover property (inrush_active);
endmodule
bind ocs_stage ocs_stage_asserts #(.W(W), .TW(TW)) u_chk (
  .clock(clock), .rst_n(rst_n), .block_in(block_in),
  .cfg_write(cfg_write), .cfg_force_enable(cfg_force_enable),
  .cfg_forced_status_select(cfg_forced_status_select),
  .grp_load(grp_load), .grp_threshold(grp_threshold),
  .remote_write(remote_write), .op_delay(op_delay),
  .stage_condition(stage_condition), .phase_trip(phase_trip),
  .threshold(threshold), .expected_time(expected_time),
  .remaining_time(remaining_time), .inrush_active(inrush_active));

/* File: bench/ocs_front.sv */
/* Measurement front end and block source model.
   Assumes the bench sets wanted values; they appear only on frames. */
module ocs_front #(
  parameter CYC = 50
) (
  input wire clock,
  input wire rst_n,
  input wire [47:0] f_set,
  input wire [47:0] t_set,
  input wire [47:0] p_set,
  input wire [47:0] h_set,
  input wire blk_set,
  output reg [47:0] fund_mag,
  output reg [47:0] trms_mag,
  output reg [47:0] pp_mag,
  output reg [47:0] harm2_mag,
  output reg block_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt_reg;
  // New values on the frame base only, never between frames
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 0;
      {fund_mag, trms_mag, pp_mag, harm2_mag} <= 192'h0;
      block_in <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == CYC - 1) ? 0 : cnt_reg + 1;
      if (cnt_reg == CYC - 1) begin
        {fund_mag, trms_mag, pp_mag, harm2_mag} <=
          {f_set, t_set, p_set, h_set};
        block_in <= blk_set;
      end
    end
  end
endmodule

/* File: bench/test_ocs_stage.sv */
/* Self-checking bench of the overcurrent stage, 50-clock cycle.
   Assumes the front end model and the bound port checker. */
`include "ocs_map.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: %0h not %0h", $time, a, b); end end
module test_ocs_stage;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [1:0] s; logic [15:0] f, t, p; logic [2:0] m;
    logic b; logic [1:0] c; logic [2:0] ps;} ocs_row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_write = 1'b0, cfg_remote_allow = 1'b0, cfg_force_enable = 1'b0;
  logic cfg_inrush_enable = 1'b0, grp_load = 1'b0, remote_write = 1'b0;
  logic blk = 1'b0;
  logic [4:0] cfg_forced_status_select = 5'h00;
  logic [1:0] cfg_mag_select = 2'h0;
  logic [15:0] cfg_inrush_limit = 16'h0001, grp_threshold = 16'h0078;
  logic [15:0] remote_threshold = 16'h0000;
  logic [18:0] op_delay = 19'h003E8, release_delay = 19'h00002;
  logic [47:0] fs = 48'h0, ts = 48'h0, ps = 48'h0, hs = 48'h0;
  wire [47:0] fund_mag, trms_mag, pp_mag, harm2_mag;
  wire block_in, inrush_active;
  wire [1:0] stage_condition;
  wire [2:0] phase_start, phase_trip;
  wire [15:0] threshold, max_mag;
  wire [18:0] expected_time;
  wire [20:0] remaining_time;
  wire [19:0] current_ratio;
  int error_cnt = 0;
  int checked = 0;
  logic [4:0] fcodes [5] = '{5'h01, 5'h03, 5'h0D, 5'h13, 5'h02};
  // Plain cases: selection, phase masks, equal level, blocking
  ocs_row_t rows [8] = '{
    '{`OCS_MAG_FUND, 16'h0079, 16'h0, 16'h0, 3'h1, 1'b0, 2'h1, 3'h1},
    '{`OCS_MAG_FUND, 16'h0078, 16'h012C, 16'h012C, 3'h7, 1'b0, 2'h0, 3'h0},
    '{`OCS_MAG_TRMS, 16'h012C, 16'h0064, 16'h0, 3'h7, 1'b0, 2'h0, 3'h0},
    '{`OCS_MAG_TRMS, 16'h0, 16'h0079, 16'h0, 3'h6, 1'b0, 2'h1, 3'h6},
    '{`OCS_MAG_PP, 16'h0, 16'h0, 16'h01F4, 3'h5, 1'b0, 2'h1, 3'h5},
    '{2'h3, 16'h00C8, 16'h0, 16'h0, 3'h3, 1'b0, 2'h1, 3'h3},
    '{`OCS_MAG_FUND, 16'h00C8, 16'h0, 16'h0, 3'h7, 1'b1, 2'h3, 3'h0},
    '{`OCS_MAG_FUND, 16'h00C8, 16'h0, 16'h0, 3'h7, 1'b0, 2'h1, 3'h7}};
  always #2 clock = ~clock;
  ocs_front #(.CYC(50)) u_front (.clock(clock), .rst_n(rst_n),
    .f_set(fs), .t_set(ts), .p_set(ps), .h_set(hs), .blk_set(blk),
    .fund_mag(fund_mag), .trms_mag(trms_mag), .pp_mag(pp_mag),
    .harm2_mag(harm2_mag), .block_in(block_in));
  ocs_stage #(.CYCLE_CLKS(50)) dut (.clock(clock), .rst_n(rst_n),
    .fund_mag(fund_mag), .trms_mag(trms_mag), .pp_mag(pp_mag),
    .harm2_mag(harm2_mag), .block_in(block_in), .cfg_write(cfg_write),
    .cfg_remote_allow(cfg_remote_allow), .cfg_force_enable(cfg_force_enable),
    .cfg_forced_status_select(cfg_forced_status_select),
    .cfg_mag_select(cfg_mag_select), .cfg_inrush_enable(cfg_inrush_enable),
    .cfg_inrush_limit(cfg_inrush_limit), .grp_load(grp_load),
    .grp_threshold(grp_threshold), .op_delay(op_delay),
    .release_delay(release_delay), .remote_write(remote_write),
    .remote_threshold(remote_threshold), .stage_condition(stage_condition),
    .phase_start(phase_start), .phase_trip(phase_trip),
    .threshold(threshold), .max_mag(max_mag), .expected_time(expected_time),
    .remaining_time(remaining_time), .current_ratio(current_ratio),
    .inrush_active(inrush_active));
  function automatic logic [47:0] rep(input logic [15:0] v, input logic [2:0] m);
    return {m[2] ? v : 16'h0, m[1] ? v : 16'h0, m[0] ? v : 16'h0};
  endfunction
  task automatic test_done();
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Config fields travel together on one write strobe
  task automatic cfg(input logic a, e, input logic [4:0] fsel,
    input logic [1:0] ms, input logic ie, input logic [15:0] lim);
    {cfg_remote_allow, cfg_force_enable, cfg_inrush_enable} = {a, e, ie};
    {cfg_forced_status_select, cfg_mag_select} = {fsel, ms};
    cfg_inrush_limit = lim;
    cfg_write = 1'b1;
    settle(1);
    cfg_write = 1'b0;
  endtask
  task automatic grp(input logic [15:0] v, input logic r);
    {grp_threshold, remote_threshold} = {v, v};
    if (r)
      remote_write = 1'b1;
    else
      grp_load = 1'b1;
    settle(1);
    if (r)
      remote_write = 1'b0;
    else
      grp_load = 1'b0;
  endtask
  task automatic mags(input logic [15:0] f, t, p, h, input logic [2:0] m);
    {fs, ts, ps, hs} = {rep(f, m), rep(t, m), rep(p, m), rep(h, m)};
  endtask
  // Bounded wait; a miss ends the run
  task automatic wait_cond(input logic [1:0] c, input int n);
    for (int i = 0; i < n && stage_condition !== c; i++)
      settle(1);
    if (stage_condition !== c) begin
      error_cnt++;
      $display("wrong value at %0t: condition wait ran out", $time);
      test_done();
    end
  endtask
  task automatic quiet_down();
    mags(16'h0, 16'h0, 16'h0, 16'h0, 3'h0);
    blk = 1'b0;
    // Let a frame and its tick carry the zeros, so old values cannot act
    settle(55);
    wait_cond(`OCS_COND_NORMAL, 600);
  endtask
  initial begin
    settle(3);
    rst_n = 1'b1;
    settle(3);
    `CHK(threshold, `OCS_THR_RST)
    `CHK(inrush_active, 1'b0)
    foreach (rows[i]) begin
      cfg(1'b0, 1'b0, `OCS_FORCE_NORMAL, rows[i].s, 1'b0, `OCS_HARM_LIM_RST);
      mags(rows[i].f, rows[i].t, rows[i].p, 16'h0, rows[i].m);
      blk = rows[i].b;
      settle(140);
      `CHK(stage_condition, rows[i].c)
      `CHK(phase_start, rows[i].ps)
      quiet_down();
    end
    // Remote write refused until allowed, group load takes over
    grp(16'h00FA, 1'b1);
    `CHK(threshold, `OCS_THR_RST)
    cfg(1'b1, 1'b0, `OCS_FORCE_NORMAL, `OCS_MAG_FUND, 1'b0, 16'h0001);
    grp(16'h00FA, 1'b1);
    `CHK(threshold, 16'h00FA)
    grp(16'h0096, 1'b0);
    `CHK(threshold, 16'h0096)
    mags(16'h012C, 16'h0, 16'h0, 16'h0, 3'h1);
    settle(140);
    `CHK(max_mag, 16'h012C)
    `CHK(current_ratio, 20'h000C8)
    grp(`OCS_THR_RST, 1'b0);
    quiet_down();
    // Release only below 97 percent of the level
    mags(16'h00C8, 16'h0, 16'h0, 16'h0, 3'h1);
    wait_cond(`OCS_COND_START, 300);
    `CHK(remaining_time <= 21'h003E8 && remaining_time > 21'h003DE, 1'b1)
    mags(16'h0075, 16'h0, 16'h0, 16'h0, 3'h1);
    settle(300);
    `CHK(stage_condition, `OCS_COND_START)
    mags(16'h0074, 16'h0, 16'h0, 16'h0, 3'h1);
    wait_cond(`OCS_COND_NORMAL, 600);
    // Short delay trips; late block drops start then blocks
    op_delay = 19'h00003;
    mags(16'h00C8, 16'h0, 16'h0, 16'h0, 3'h1);
    wait_cond(`OCS_COND_TRIP, 400);
    `CHK(phase_trip, 3'h1)
    `CHK(expected_time, 19'h00003)
    quiet_down();
    op_delay = 19'h003E8;
    mags(16'h00C8, 16'h0, 16'h0, 16'h0, 3'h1);
    wait_cond(`OCS_COND_START, 300);
    blk = 1'b1;
    wait_cond(`OCS_COND_BLOCKED, 800);
    quiet_down();
    // Inrush at exactly the limit holds trip off
    cfg(1'b0, 1'b0, `OCS_FORCE_NORMAL, `OCS_MAG_FUND, 1'b1, 16'h05DC);
    op_delay = 19'h00003;
    mags(16'h00C8, 16'h0, 16'h0, 16'h001E, 3'h1);
    settle(400);
    `CHK(inrush_active, 1'b1)
    `CHK(stage_condition, `OCS_COND_START)
    mags(16'h00C8, 16'h0, 16'h0, 16'h001D, 3'h1);
    wait_cond(`OCS_COND_TRIP, 300);
    `CHK(inrush_active, 1'b0)
    quiet_down();
    // Forcing codes; group load leaves forcing alone
    foreach (fcodes[i]) begin
      cfg(1'b0, 1'b1, fcodes[i], `OCS_MAG_FUND, 1'b0, 16'h0001);
      settle(3);
      if (fcodes[i][4])
        `CHK(phase_trip, fcodes[i][2:0])
      else if (fcodes[i][3])
        `CHK(phase_start, fcodes[i][2:0])
      else
        `CHK(stage_condition, fcodes[i][1:0])
    end
    grp(16'h00FA, 1'b0);
    settle(2);
    `CHK(stage_condition, `OCS_COND_TRIP)
    cfg(1'b0, 1'b0, `OCS_FORCE_NORMAL, `OCS_MAG_FUND, 1'b0, 16'h0001);
    wait_cond(`OCS_COND_NORMAL, 10);
    // Reset in mid-run restores the defaults at once
    rst_n = 1'b0;
    settle(1);
    `CHK(threshold, `OCS_THR_RST)
    rst_n = 1'b1;
    settle(3);
    `CHK(stage_condition, `OCS_COND_NORMAL)
    test_done();
  end
endmodule
